// ===== src/hlc_input_map.sv
`timescale 1ns/10ps
`include "hlc_regs.svh"

// Maps a 0..100 % input level onto a signed drive amplitude and brake request
module hlc_input_map (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic [7:0] level_i,
	input wire logic bidir_i,
	input wire hlc_pkg::hlc_phase_t phase_i,
	output hlc_pkg::hlc_drive_t drive_o
);

	hlc_pkg::hlc_drive_t drive_ff; // Registered mapping result
	hlc_pkg::hlc_drive_t nxt_drive; // Combinational mapping
	logic signed [8:0] centred; // Level minus midpoint

	// Mapping of the level by direction mode and loop mode
	always_comb
	begin
		centred = $signed({1'b0, level_i}) - $signed({1'b0, `HLC_MID_SCALE});
		nxt_drive = '0;
		if (!bidir_i)
		begin
			// Full 8-bit level reaches the output, gaining one bit of resolution
			nxt_drive.amplitude = $signed({1'b0, level_i}); // [RQ10]
			nxt_drive.brake = phase_i.fb_brake; // [RQ10]
		end
		else if (phase_i.closed_loop)
		begin
			// Lower half gives no drive; loop decides braking
			nxt_drive.amplitude = (level_i < `HLC_MID_SCALE) ? 9'sh000 : 9'(centred <<< 1);
			nxt_drive.brake = phase_i.fb_brake;
		end
		else
		begin
			// Open loop: 50 % is zero, below it is reverse drive
			nxt_drive.amplitude = 9'(centred <<< 1); // [RQ12]
			nxt_drive.brake = (level_i < `HLC_MID_SCALE); // [RQ12]
		end
	end

	// Output register
	always_ff @(posedge clk_sys_i)
	begin
		if (!rst_n_i)
			drive_ff <= '0;
		else
			drive_ff <= nxt_drive;
	end

	assign drive_o = drive_ff;

endmodule : hlc_input_map

// ===== src/hlc_loop_ctrl.sv
`timescale 1ns/10ps
`include "hlc_regs.svh"

// Overview of operation
// [RQ1] Boost bit raises loop gain during overdrive
// [RQ2] Bias bit enables input pin common-mode drive
// [RQ3] Host keeps bias off for PWM, trigger
// [RQ4] Resonant drive time: field*0.1ms plus 0.5ms
// [RQ5] Rotating sample interval: field*0.2ms plus 1ms
// [RQ6] Resonant field only seeds self-adjusting drive time
// [RQ7] Host sets drive time near half period
// [RQ8] Second register at 0x1C, documented bit layout
// [RQ9] Direction bit: 0 unidirectional, 1 bidirectional
// [RQ10] Unidirectional: linear scale, feedback braking, extra bit
// [RQ11] Host uses unidirectional only in closed loop
// [RQ12] Bidirectional open loop: 50% zero, brake below
// [RQ13] Stabilizer bit lowers gain near brake end
// [RQ14] Sample field picks 150/200/250/300 us
// [RQ15] Reserved bit reads zero, resets 0x93
// [RQ16] Whole-register writes apply at next decision
module hlc_loop_ctrl #(
	parameter int CNT_W = 24,
	parameter int RES_STEP_CYC = `HLC_RES_STEP_NS / `HLC_CLK_PERIOD_NS,
	parameter int RES_BASE_CYC = `HLC_RES_BASE_NS / `HLC_CLK_PERIOD_NS,
	parameter int ROT_STEP_CYC = `HLC_ROT_STEP_NS / `HLC_CLK_PERIOD_NS,
	parameter int ROT_BASE_CYC = `HLC_ROT_BASE_NS / `HLC_CLK_PERIOD_NS,
	parameter int SAMPLE_BASE_CYC = `HLC_SAMPLE_BASE_NS / `HLC_CLK_PERIOD_NS,
	parameter int SAMPLE_STEP_CYC = `HLC_SAMPLE_STEP_NS / `HLC_CLK_PERIOD_NS,
	parameter int ADJ_STEP_CYC = `HLC_ADJ_STEP_NS / `HLC_CLK_PERIOD_NS
) (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	output logic [7:0] reg_rdata_o,
	input wire logic actuator_type_select_i,
	input wire logic engine_decision_i,
	input wire logic period_late_i,
	input wire logic period_early_i,
	input wire hlc_pkg::hlc_phase_t phase_i,
	input wire logic [7:0] input_level_i,
	output logic input_common_mode_bias_o,
	output hlc_pkg::hlc_gain_t loop_gain_o,
	output logic [CNT_W-1:0] drive_time_cyc_o,
	output logic [CNT_W-1:0] sample_time_cyc_o,
	output logic bemf_sample_o,
	output logic [1:0] blanking_time_o,
	output logic [1:0] current_dissipate_period_o,
	output hlc_pkg::hlc_drive_t drive_o
);

	// Software-visible registers
	hlc_pkg::hlc_ctrl_one_t ctrl_one_ff;
	hlc_pkg::hlc_ctrl_two_t ctrl_two_ff;
	// Working copies used by the engine
	hlc_pkg::hlc_ctrl_one_t act_one_ff;
	hlc_pkg::hlc_ctrl_two_t act_two_ff;
	logic act_type_ff; // Actuator type captured with the config
	logic [7:0] rdata_ff; // Read data register
	logic [CNT_W-1:0] drive_cyc_ff; // Live drive time / sample interval
	logic [CNT_W-1:0] nxt_drive_cyc;
	logic [CNT_W-1:0] guess_cyc; // Drive time implied by the field
	logic [CNT_W-1:0] sample_cyc_ff; // Resonance sampling period
	logic [CNT_W-1:0] tick_cnt_ff; // Interval timer
	logic bemf_sample_ff; // One-cycle sample strobe
	logic reseed; // Config change needs a fresh seed
	logic [1:0] wr_sel; // Register hit on the write path
	hlc_pkg::hlc_gain_t gain_ff;
	hlc_pkg::hlc_gain_t nxt_gain;

	// Address decode shared by read and write paths
	function automatic logic [1:0] reg_sel(input logic [7:0] addr);
		reg_sel = {addr == `HLC_ADDR_LOOP_CTRL_TWO, addr == `HLC_ADDR_LOOP_CTRL_ONE};
	endfunction : reg_sel

	// Decoded once, then bit-selected; a call result cannot be indexed directly
	assign wr_sel = reg_sel(reg_addr_i);

	// Drive time from field for either actuator type
	function automatic logic [CNT_W-1:0] drive_guess(input logic [4:0] fld, input logic resonant);
		if (resonant)
			drive_guess = CNT_W'(fld) * CNT_W'(RES_STEP_CYC) + CNT_W'(RES_BASE_CYC); // [RQ4]
		else
			drive_guess = CNT_W'(fld) * CNT_W'(ROT_STEP_CYC) + CNT_W'(ROT_BASE_CYC); // [RQ5]
	endfunction : drive_guess

	// Register writes, whole byte at once
	always_ff @(posedge clk_sys_i)
	begin
		if (!rst_n_i)
		begin
			ctrl_one_ff <= `HLC_RST_LOOP_CTRL_ONE; // [RQ15]
			ctrl_two_ff <= `HLC_RST_LOOP_CTRL_TWO;
		end
		else if (reg_wr_i)
		begin
			if (wr_sel[0])
				ctrl_one_ff <= reg_wdata_i & `HLC_WMASK_LOOP_CTRL_ONE; // [RQ15] [RQ16]
			if (wr_sel[1])
				ctrl_two_ff <= reg_wdata_i; // [RQ8] [RQ16]
		end
	end

	// Read port, one cycle latency; unmapped addresses read zero
	always_ff @(posedge clk_sys_i)
	begin
		if (!rst_n_i)
			rdata_ff <= 8'h00;
		else if (reg_rd_i)
		begin
			case (reg_sel(reg_addr_i))
				2'b01: rdata_ff <= ctrl_one_ff & `HLC_WMASK_LOOP_CTRL_ONE; // [RQ15]
				2'b10: rdata_ff <= ctrl_two_ff; // [RQ8]
				default: rdata_ff <= 8'h00;
			endcase
		end
	end

	// Working copy refreshed only at an engine decision point, so a
	// half-written setup never splits across one drive decision
	always_ff @(posedge clk_sys_i)
	begin
		if (!rst_n_i)
		begin
			act_one_ff <= `HLC_RST_LOOP_CTRL_ONE;
			act_two_ff <= `HLC_RST_LOOP_CTRL_TWO;
			act_type_ff <= 1'b0;
		end
		else if (engine_decision_i)
		begin
			act_one_ff <= ctrl_one_ff; // [RQ16]
			act_two_ff <= ctrl_two_ff; // [RQ16]
			act_type_ff <= actuator_type_select_i;
		end
	end

	// Reseed when the applied field or actuator type changes
	assign reseed = engine_decision_i &&
		((ctrl_one_ff.drive_period != act_one_ff.drive_period) || (actuator_type_select_i != act_type_ff));
	assign guess_cyc = drive_guess(ctrl_one_ff.drive_period, actuator_type_select_i);

	// Live drive time: seeded from the field, then tracked in resonant mode
	always_comb
	begin
		nxt_drive_cyc = drive_cyc_ff;
		if (reseed)
			nxt_drive_cyc = guess_cyc; // [RQ6]
		else if (act_type_ff && period_late_i && !period_early_i)
			nxt_drive_cyc = drive_cyc_ff + CNT_W'(ADJ_STEP_CYC); // [RQ6]
		else if (act_type_ff && period_early_i && !period_late_i
			&& drive_cyc_ff > CNT_W'(2 * ADJ_STEP_CYC))
			nxt_drive_cyc = drive_cyc_ff - CNT_W'(ADJ_STEP_CYC); // [RQ6]
	end

	// Drive time register; tracking stops short of zero so timers never stall.
	// Reset value is the rotating interval of the default field, so the
	// engine matches its applied config before the first decision.
	always_ff @(posedge clk_sys_i)
	begin
		if (!rst_n_i)
			drive_cyc_ff <= CNT_W'(ROT_BASE_CYC + ROT_STEP_CYC * `HLC_RST_DRIVE_PERIOD); // [RQ5]
		else
			drive_cyc_ff <= nxt_drive_cyc;
	end

	// Resonance sampling period from its two-bit field
	always_ff @(posedge clk_sys_i)
	begin
		if (!rst_n_i)
			sample_cyc_ff <= CNT_W'(SAMPLE_BASE_CYC);
		else
			sample_cyc_ff <= CNT_W'(act_two_ff.sample_time) * CNT_W'(SAMPLE_STEP_CYC)
				+ CNT_W'(SAMPLE_BASE_CYC); // [RQ14]
	end

	// Interval timer: back-EMF sample strobe in rotating mode,
	// resonance sample strobe in resonant mode
	always_ff @(posedge clk_sys_i)
	begin
		if (!rst_n_i || reseed)
		begin
			tick_cnt_ff <= '0;
			bemf_sample_ff <= 1'b0;
		end
		else if (tick_cnt_ff + CNT_W'(1) >= (act_type_ff ? sample_cyc_ff : drive_cyc_ff))
		begin
			tick_cnt_ff <= '0;
			bemf_sample_ff <= 1'b1; // [RQ5] [RQ14]
		end
		else
		begin
			tick_cnt_ff <= tick_cnt_ff + CNT_W'(1);
			bemf_sample_ff <= 1'b0;
		end
	end

	// Loop gain by phase; brake stabilisation outranks overdrive boost
	always_comb
	begin
		case ({act_two_ff.brake_gain_reduce && phase_i.brake_near_done,
			act_one_ff.overdrive_gain_boost && phase_i.overdrive})
			2'b10,
			2'b11: nxt_gain = hlc_pkg::HLC_GAIN_REDUCED; // [RQ13]
			2'b01: nxt_gain = hlc_pkg::HLC_GAIN_BOOST; // [RQ1]
			default: nxt_gain = hlc_pkg::HLC_GAIN_NORMAL;
		endcase
	end

	// Gain register
	always_ff @(posedge clk_sys_i)
	begin
		if (!rst_n_i)
			gain_ff <= hlc_pkg::HLC_GAIN_NORMAL;
		else
			gain_ff <= nxt_gain;
	end

	// Input level interpretation per direction select
	hlc_input_map u_input_map (
		.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_i),
		.level_i(input_level_i),
		.bidir_i(act_two_ff.input_direction_select), // [RQ9]
		.phase_i(phase_i),
		.drive_o(drive_o)
	);

	// Outputs, all from registers
	assign reg_rdata_o = rdata_ff;
	assign input_common_mode_bias_o = act_one_ff.input_common_mode_bias; // [RQ2]
	assign loop_gain_o = gain_ff;
	assign drive_time_cyc_o = drive_cyc_ff;
	assign sample_time_cyc_o = sample_cyc_ff;
	assign bemf_sample_o = bemf_sample_ff;
	assign blanking_time_o = act_two_ff.blanking_time;
	assign current_dissipate_period_o = act_two_ff.current_dissipate_period;

endmodule : hlc_loop_ctrl

// ===== src/hlc_pkg.sv
package hlc_pkg;

	// First loop control register layout
	typedef struct packed {
		logic overdrive_gain_boost;
		logic reserved;
		logic input_common_mode_bias;
		logic [4:0] drive_period;
	} hlc_ctrl_one_t;

	// Second loop control register layout
	typedef struct packed {
		logic input_direction_select;
		logic brake_gain_reduce;
		logic [1:0] sample_time;
		logic [1:0] blanking_time;
		logic [1:0] current_dissipate_period;
	} hlc_ctrl_two_t;

	// Loop gain selection handed to the drive engine
	typedef enum logic [1:0] {
		HLC_GAIN_NORMAL,
		HLC_GAIN_BOOST,
		HLC_GAIN_REDUCED
	} hlc_gain_t;

	// Drive-engine phase indications
	typedef struct packed {
		logic closed_loop;
		logic overdrive;
		logic brake_near_done;
		logic fb_brake;
	} hlc_phase_t;

	// Mapped drive request
	typedef struct packed {
		logic signed [8:0] amplitude;
		logic brake;
	} hlc_drive_t;

endpackage : hlc_pkg

// ===== src/hlc_regs.svh
`ifndef HLC_REGS_SVH
`define HLC_REGS_SVH

// Register offsets on the serial control port
`define HLC_ADDR_LOOP_CTRL_ONE 8'h1b
`define HLC_ADDR_LOOP_CTRL_TWO 8'h1c

// Reset values, field defaults folded in
`define HLC_RST_LOOP_CTRL_ONE 8'h93
`define HLC_RST_LOOP_CTRL_TWO 8'hf5
// Default drive-period field, used to seed the live drive time at reset
`define HLC_RST_DRIVE_PERIOD 5'h13

// Field positions
`define HLC_BIT_BOOST 7
`define HLC_BIT_RSVD 6
`define HLC_BIT_BIAS 5
`define HLC_BIT_DIR 7
`define HLC_BIT_BRAKE_STAB 6

// Writable bits of the first register; reserved bit held at zero
`define HLC_WMASK_LOOP_CTRL_ONE 8'hbf

// Input scale midpoint (50 %)
`define HLC_MID_SCALE 8'h80

// Timing, all in ns
`define HLC_CLK_PERIOD_NS 5
`define HLC_RES_STEP_NS 100000
`define HLC_RES_BASE_NS 500000
`define HLC_ROT_STEP_NS 200000
`define HLC_ROT_BASE_NS 1000000
`define HLC_SAMPLE_BASE_NS 150000
`define HLC_SAMPLE_STEP_NS 50000
`define HLC_ADJ_STEP_NS 1000

`endif

// ===== tb/hlc_loop_ctrl_asserts.sv
`timescale 1ns/10ps
// Port checks on the loop control block
module hlc_loop_asserts #(
	parameter int CNT_W = 24,
	parameter int SAMPLE_BASE_CYC = 30000,
	parameter int SAMPLE_STEP_CYC = 10000
) (
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_rdata_o,
	input wire logic engine_decision_i,
	input wire hlc_pkg::hlc_phase_t phase_i,
	input wire logic [7:0] input_level_i,
	input wire logic input_common_mode_bias_o,
	input wire hlc_pkg::hlc_gain_t loop_gain_o,
	input wire logic [CNT_W-1:0] sample_time_cyc_o,
	input wire logic bemf_sample_o,
	input wire logic [1:0] blanking_time_o,
	input wire hlc_pkg::hlc_drive_t drive_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);
	// Read outside both registers
	sequence s_rd_other;
		reg_rd_i && reg_addr_i != 8'h1b && reg_addr_i != 8'h1c;
	endsequence
	a_rd_unmapped: assert property (s_rd_other |=> reg_rdata_o == 8'h00)
		else $error("unmapped read not zero");
	a_rsvd_zero: assert property (reg_rd_i && reg_addr_i == 8'h1b |=> !reg_rdata_o[6])
		else $error("reserved bit read as one");
	a_gain_normal: assert property (!phase_i.overdrive && !phase_i.brake_near_done
		|=> loop_gain_o == hlc_pkg::HLC_GAIN_NORMAL)
		else $error("gain not normal");
	a_gain_boost: assert property (loop_gain_o == hlc_pkg::HLC_GAIN_BOOST |-> $past(phase_i.overdrive))
		else $error("boost outside overdrive");
	a_gain_reduce: assert property (loop_gain_o == hlc_pkg::HLC_GAIN_REDUCED
		|-> $past(phase_i.brake_near_done))
		else $error("reduced gain without brake end");
	a_brake_closed: assert property (phase_i.closed_loop |=> drive_o.brake == $past(phase_i.fb_brake))
		else $error("closed loop brake not feedback");
	a_no_brake_high: assert property (!phase_i.closed_loop && !phase_i.fb_brake && input_level_i[7]
		|=> !drive_o.brake)
		else $error("brake at upper half input");
	a_zero_closed: assert property (phase_i.closed_loop && input_level_i == 8'h00
		|=> drive_o.amplitude == 9'h000)
		else $error("zero input gave output");
	a_bemf_pulse: assert property (bemf_sample_o |=> !bemf_sample_o)
		else $error("sample pulse too long");
	a_sample_set: assert property (sample_time_cyc_o >= SAMPLE_BASE_CYC
		&& sample_time_cyc_o <= SAMPLE_BASE_CYC + 3 * SAMPLE_STEP_CYC
		&& (sample_time_cyc_o - SAMPLE_BASE_CYC) % SAMPLE_STEP_CYC == 0)
		else $error("sample period off grid");
	a_apply_only: assert property ($changed({input_common_mode_bias_o, blanking_time_o})
		|-> $past(engine_decision_i) || $past(engine_decision_i, 2))
		else $error("field changed without decision");
endmodule : hlc_loop_asserts

// ===== tb/tb_top.sv
`timescale 1ns/10ps
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin miscompares++; $display("Error %s exp %h got %h", n, e, g); end end
// Bench for the loop control registers
module tb_top;
	logic clk_sys_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic wr = 1'b0, rd = 1'b0, typ = 1'b0, dec = 1'b0, late = 1'b0, early = 1'b0;
	logic [7:0] addr = 8'h00, wdata = 8'h00, level = 8'h00, rdata;
	hlc_pkg::hlc_phase_t phase = '0;
	hlc_pkg::hlc_gain_t gain;
	hlc_pkg::hlc_drive_t drive;
	logic bias, bemf;
	logic [1:0] blank, diss;
	logic [23:0] dtime, stime;
	int miscompares = 0;
	int samples_checked = 0;
	// Rows: address, write value, read-back
	logic [23:0] rows [7] = '{24'h1bffbf, 24'h1b4000, 24'h1b2525, 24'h1c0000, 24'h1ca5a5, 24'h1dff00, 24'h001200};
	// Short drive counts keep the run brief; sampling periods keep their full counts
	hlc_loop_ctrl #(.RES_STEP_CYC(10), .RES_BASE_CYC(50), .ROT_STEP_CYC(20), .ROT_BASE_CYC(100),
		.ADJ_STEP_CYC(2)) hlc_loop_ctrl_i (
		.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr),
		.reg_wdata_i(wdata), .reg_rdata_o(rdata), .actuator_type_select_i(typ), .engine_decision_i(dec),
		.period_late_i(late), .period_early_i(early), .phase_i(phase), .input_level_i(level),
		.input_common_mode_bias_o(bias), .loop_gain_o(gain), .drive_time_cyc_o(dtime),
		.sample_time_cyc_o(stime), .bemf_sample_o(bemf), .blanking_time_o(blank),
		.current_dissipate_period_o(diss), .drive_o(drive));
	// 200 MHz clock
	initial
	begin
		forever #2.5 clk_sys_i = ~clk_sys_i;
	end
	task automatic step(input int n);
		repeat (n) @(posedge clk_sys_i);
		#1;
	endtask : step
	// One-cycle write strobe
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys_i);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk_sys_i);
		wr <= 1'b0;
	endtask : wr_reg
	// Read data lands one cycle after the read edge
	task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk_sys_i);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk_sys_i);
		rd <= 1'b0;
		#1;
		`CHK("rdata", e, rdata)
	endtask : rd_reg
	// Decision pulse, then wait for the delayed sample period
	task automatic apply(input logic t);
		@(posedge clk_sys_i);
		typ <= t;
		dec <= 1'b1;
		@(posedge clk_sys_i);
		dec <= 1'b0;
		step(2);
	endtask : apply
	task automatic pin(input logic [7:0] lv, input hlc_pkg::hlc_phase_t ph);
		@(posedge clk_sys_i);
		level <= lv;
		phase <= ph;
		step(2);
	endtask : pin
	task automatic report_and_stop();
		if (miscompares == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : report_and_stop
	// Hang guard
	initial
	begin
		#200000;
		miscompares++;
		report_and_stop();
	end
	initial
	begin
		logic [7:0] lv;
		int n;
		repeat (12) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		step(2);
		`CHK("dtime", 24'd480, dtime)
		`CHK("stime", 24'd60000, stime)
		`CHK("blank", 2'h1, blank)
		`CHK("diss", 2'h1, diss)
		`CHK("bias", 1'b0, bias)
		rd_reg(8'h1b, 8'h93);
		rd_reg(8'h1c, 8'hf5);
		for (int i = 0; i < 7; i++)
		begin
			wr_reg(rows[i][23:16], rows[i][15:8]);
			rd_reg(rows[i][23:16], rows[i][7:0]);
		end
		// Resonant seed, then live adjustment both ways
		wr_reg(8'h1b, 8'h80); // 0.5 ms seed suits a short actuator period
		wr_reg(8'h1c, 8'hcb);
		apply(1'b1);
		`CHK("dtime", 24'd50, dtime)
		`CHK("diss", 2'h3, diss)
		@(posedge clk_sys_i);
		late <= 1'b1;
		@(posedge clk_sys_i);
		late <= 1'b0;
		step(2);
		`CHK("dtime", 24'd52, dtime)
		@(posedge clk_sys_i);
		early <= 1'b1;
		@(posedge clk_sys_i);
		early <= 1'b0;
		step(2);
		`CHK("dtime", 24'd50, dtime)
		// Write alone must not reach the engine
		wr_reg(8'h1b, 8'h3f); // bias only set for analog input use
		step(2);
		`CHK("bias", 1'b0, bias)
		apply(1'b1);
		`CHK("bias", 1'b1, bias)
		`CHK("dtime", 24'd360, dtime)
		apply(1'b0);
		`CHK("dtime", 24'd720, dtime)
		wr_reg(8'h1b, 8'h80);
		for (int k = 0; k < 4; k++)
		begin
			wr_reg(8'h1c, {2'b11, k[1:0], 4'h5});
			apply(1'b0);
			`CHK("stime", 24'(30000 + 10000 * k), stime)
		end
		`CHK("dtime", 24'd100, dtime)
		// Back-EMF strobe period equals the rotating interval
		n = 0;
		while (bemf !== 1'b1 && n < 300)
		begin
			step(1);
			n++;
		end
		step(1);
		n = 1;
		while (bemf !== 1'b1 && n < 300)
		begin
			step(1);
			n++;
		end
		`CHK("bemf", 100, n)
		if (n >= 300)
			report_and_stop();
		pin(8'h00, 4'b1100);
		`CHK("gain", hlc_pkg::HLC_GAIN_BOOST, gain)
		pin(8'h00, 4'b1010);
		`CHK("gain", hlc_pkg::HLC_GAIN_REDUCED, gain)
		// Boost and stabilizer off, unidirectional input
		wr_reg(8'h1b, 8'h00);
		wr_reg(8'h1c, 8'h35); // unidirectional only with closed-loop phases
		apply(1'b0);
		pin(8'h00, 4'b1110);
		`CHK("gain", hlc_pkg::HLC_GAIN_NORMAL, gain)
		pin(8'hc0, 4'b1000);
		`CHK("drive", 10'h180, drive)
		pin(8'hff, 4'b1001);
		`CHK("drive", 10'h1ff, drive)
		wr_reg(8'h1c, 8'hf5);
		apply(1'b0);
		pin(8'h40, 4'b1000);
		`CHK("drive", 10'h000, drive)
		pin(8'hc0, 4'b1000);
		`CHK("drive", 10'h100, drive)
		// Open loop, bidirectional: quarter steps of input
		for (int i = 0; i < 5; i++)
		begin
			lv = (i == 4) ? 8'hff : 8'(i * 64);
			pin(lv, 4'b0000);
			`CHK("drive", {{lv, 1'b0} - 9'h100, lv < 8'h80}, drive)
		end
		// Mid-run reset brings back every default
		@(posedge clk_sys_i);
		rst_n_i <= 1'b0;
		repeat (2) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		step(2);
		`CHK("dtime", 24'd480, dtime)
		`CHK("stime", 24'd60000, stime)
		`CHK("gain", hlc_pkg::HLC_GAIN_NORMAL, gain)
		`CHK("bias", 1'b0, bias)
		rd_reg(8'h1b, 8'h93);
		rd_reg(8'h1c, 8'hf5);
		step(120);
		report_and_stop();
	end
endmodule : tb_top
bind hlc_loop_ctrl hlc_loop_asserts #(.CNT_W(CNT_W), .SAMPLE_BASE_CYC(SAMPLE_BASE_CYC),
	.SAMPLE_STEP_CYC(SAMPLE_STEP_CYC)) hlc_loop_asserts_i (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
	.reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_rdata_o(reg_rdata_o),
	.engine_decision_i(engine_decision_i), .phase_i(phase_i), .input_level_i(input_level_i),
	.input_common_mode_bias_o(input_common_mode_bias_o), .loop_gain_o(loop_gain_o),
	.sample_time_cyc_o(sample_time_cyc_o), .bemf_sample_o(bemf_sample_o),
	.blanking_time_o(blanking_time_o), .drive_o(drive_o));
